//--- design/scad_decode.sv
`timescale 1ns/1ps
module scad_decode
  import scad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instrValid,
  input wire logic [31:0] instr,
  input wire logic [4:0] coreMode,
  input wire logic [3:0] coreFlags,
  input wire logic [31:0] coreWriteData,
  input wire logic [31:0] cacheIdInfo,
  output logic undefTrap,
  output logic done,
  output logic readValid,
  output logic [3:0] readDest,
  output logic [31:0] readData,
  output logic writeStrobe,
  output logic [3:0] primaryRegSelect,
  output logic [3:0] secondaryRegSelect,
  output logic [2:0] subOp1,
  output logic [2:0] subOp2,
  output logic [31:0] writeData
);
  import scad_pkg::*;

  // ==========================================
  // Decode
  function automatic logic isSysCp(input logic [31:0] w);
    isSysCp = (w[CpNumHi:CpNumLo] == SysCpNum);
  endfunction : isSysCp

  logic condPass;
  logic isXfer, isOther, privileged, trapNow, doWrite, doRead;
  scad_op_t op;

  scad_cond_eval uCond (
    .cond(instr[CondHi:CondLo]),
    .flags(coreFlags),
    .pass(condPass)
  );

  always_comb begin
    isXfer = instr[ClassHi:ClassLo] == XferClass && isSysCp(instr) && instr[XferBit];
    // Data op: class 1110 bit 4 clear; load/store: class 110x
    isOther = isSysCp(instr) && ((instr[ClassHi:ClassLo] == XferClass && !instr[XferBit])
              || instr[ClassHi:ClassLo+1] == LoadStoreClass);
    privileged = (coreMode != UserMode);
    op = SCAD_NONE;
    if (instrValid && condPass) begin
      if (isOther || (isXfer && !privileged)) begin
        op = SCAD_TRAP;
      end else if (isXfer) begin
        op = instr[DirBit] ? SCAD_READ : SCAD_WRITE;
      end
    end
    trapNow = (op == SCAD_TRAP);
    doWrite = (op == SCAD_WRITE);
    doRead = (op == SCAD_READ);
  end

  // ==========================================
  // Register file, sixteen words
  logic [31:0] regs [RegCount];
  logic [31:0] next_regs [RegCount];
  logic [3:0] sel;
  assign sel = instr[PrimHi:PrimLo];

  always_comb begin
    for (int i = 0; i < RegCount; i++) begin
      next_regs[i] = regs[i];
    end
    // Register zero ignores writes
    if (doWrite && sel != 4'h0) begin
      next_regs[sel] = coreWriteData;
    end
  end

  generate
    for (genvar g = 0; g < RegCount; g++) begin : gRegs
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          regs[g] <= RegReset;
        end else begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // Outputs, all registered
  logic next_undefTrap, next_done, next_readValid, next_writeStrobe;
  logic [3:0] next_readDest, next_prim, next_sec;
  logic [2:0] next_sub1, next_sub2;
  logic [31:0] next_readData, next_writeData;

  always_comb begin
    next_undefTrap = trapNow;
    next_done = instrValid;
    next_readValid = doRead;
    next_writeStrobe = doWrite;
    next_readDest = doRead ? instr[CoreRegHi:CoreRegLo] : 4'h0;
    next_prim = sel;
    next_sec = instr[SecHi:SecLo];
    next_sub1 = instr[ZeroHi:ZeroLo];
    next_sub2 = instr[Sub2Hi:Sub2Lo];
    next_writeData = coreWriteData;
    next_readData = 32'h00000000;
    if (doRead) begin
      next_readData = (sel == 4'h0) ? cacheIdInfo : regs[sel];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      undefTrap <= 1'b0;
      done <= 1'b0;
      readValid <= 1'b0;
      writeStrobe <= 1'b0;
      readDest <= 4'h0;
      primaryRegSelect <= 4'h0;
      secondaryRegSelect <= 4'h0;
      subOp1 <= 3'h0;
      subOp2 <= 3'h0;
      writeData <= IdReset;
      readData <= IdReset;
    end else begin
      undefTrap <= next_undefTrap;
      done <= next_done;
      readValid <= next_readValid;
      writeStrobe <= next_writeStrobe;
      readDest <= next_readDest;
      primaryRegSelect <= next_prim;
      secondaryRegSelect <= next_sec;
      subOp1 <= next_sub1;
      subOp2 <= next_sub2;
      writeData <= next_writeData;
      readData <= next_readData;
    end
  end

  // ==========================================
  // Checks
  // Steps of two behaviours are named once; s_user_xfer is shared by two properties
  sequence s_user_xfer;
    instrValid && condPass && isXfer && !privileged;
  endsequence

  // Back-to-back write and read of one live register
  sequence s_write_then_read;
    doWrite && sel != 4'h0 ##1 doRead && sel == $past(sel);
  endsequence

  a_user_trap: assert property (@(posedge clk) disable iff (!rst_b)
    s_user_xfer
    |=> undefTrap && !readValid && !writeStrobe)
    else $error("user transfer not trapped");

  // A trapped write must leave the target untouched
  a_user_keep: assert property (@(posedge clk) disable iff (!rst_b)
    s_user_xfer ##0 !instr[DirBit]
    |=> regs[$past(sel)] == $past(regs[sel]))
    else $error("user write landed");

  a_other_trap: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid && condPass && isOther
    |=> undefTrap)
    else $error("other op not trapped");

  a_other_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid && condPass && isOther
    |=> !readValid && !writeStrobe)
    else $error("other op moved data");

  a_cond_fail: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid && !condPass
    |=> !undefTrap && !readValid && !writeStrobe && done)
    else $error("failed condition acted");

  a_done_follow: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid
    |=> done)
    else $error("instruction not completed");

  // Pulses follow instrValid one cycle later and stay high while it is held; an idle cycle must clear them all
  a_done_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !instrValid
    |=> !done && !undefTrap && !readValid && !writeStrobe)
    else $error("pulse without instruction");

  a_read_dir: assert property (@(posedge clk) disable iff (!rst_b)
    readValid
    |-> !writeStrobe && !undefTrap)
    else $error("read and write together");

  a_write_dir: assert property (@(posedge clk) disable iff (!rst_b)
    writeStrobe
    |-> !$past(instr[DirBit]) && !readValid && !undefTrap)
    else $error("write with read direction");

  a_write_data: assert property (@(posedge clk) disable iff (!rst_b)
    writeStrobe
    |-> writeData == $past(coreWriteData))
    else $error("write data not passed");

  a_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !readValid
    |-> readData == 32'h00000000 && readDest == 4'h0)
    else $error("read outputs not cleared");

  a_priv_only: assert property (@(posedge clk) disable iff (!rst_b)
    (writeStrobe || readValid)
    |-> $past(coreMode) != UserMode)
    else $error("unprivileged access");

  a_write_land: assert property (@(posedge clk) disable iff (!rst_b)
    doWrite && sel != 4'h0
    |=> regs[$past(sel)] == $past(coreWriteData))
    else $error("write lost");

  a_zero_ro: assert property (@(posedge clk) disable iff (!rst_b)
    doRead && sel == 4'h0
    |=> readData == $past(cacheIdInfo))
    else $error("id read");

  a_zero_keep: assert property (@(posedge clk) disable iff (!rst_b)
    doWrite && sel == 4'h0
    |=> regs[0] == $past(regs[0]))
    else $error("register zero written");

  a_recognise: assert property (@(posedge clk) disable iff (!rst_b)
    (writeStrobe || readValid)
    |-> $past(instr[XferBit]) && $past(instr[CpNumHi:CpNumLo]) == SysCpNum
    && $past(instr[ClassHi:ClassLo]) == XferClass)
    else $error("bad recognition");

  a_dest_reg: assert property (@(posedge clk) disable iff (!rst_b)
    doRead
    |=> readDest == $past(instr[CoreRegHi:CoreRegLo]))
    else $error("dest");

  a_qualify: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid
    |=> secondaryRegSelect == $past(instr[SecHi:SecLo])
    && subOp1 == $past(instr[ZeroHi:ZeroLo]) && subOp2 == $past(instr[Sub2Hi:Sub2Lo]))
    else $error("qualifier fields");

  // Compared with the data written, not the stored word, to catch a bad store
  a_sixteen: assert property (@(posedge clk) disable iff (!rst_b)
    s_write_then_read
    |=> readData == $past(coreWriteData, 2))
    else $error("readback");
endmodule : scad_decode

//--- design/scad_pkg.sv
package scad_pkg;
  // ==========================================
  // Instruction field positions
  localparam int CondHi = 31;
  localparam int CondLo = 28;
  localparam int ClassHi = 27;
  localparam int ClassLo = 24;
  localparam int ZeroHi = 23;
  localparam int ZeroLo = 21;
  localparam int DirBit = 20;
  localparam int PrimHi = 19;
  localparam int PrimLo = 16;
  localparam int CoreRegHi = 15;
  localparam int CoreRegLo = 12;
  localparam int CpNumHi = 11;
  localparam int CpNumLo = 8;
  localparam int Sub2Hi = 7;
  localparam int Sub2Lo = 5;
  localparam int XferBit = 4;
  localparam int SecHi = 3;
  localparam int SecLo = 0;
  // ==========================================
  // Encodings
  localparam logic [3:0] XferClass = 4'he;
  localparam logic [3:0] SysCpNum = 4'hf;
  localparam logic [2:0] LoadStoreClass = 3'h6;
  localparam logic [4:0] UserMode = 5'h10;
  localparam logic [31:0] IdReset = 32'h00000000;
  localparam logic [31:0] RegReset = 32'h00000000;
  localparam int RegCount = 16;
  typedef enum logic [1:0] {SCAD_NONE, SCAD_WRITE, SCAD_READ, SCAD_TRAP} scad_op_t;
endpackage : scad_pkg

//--- design/scad_cond_eval.sv
`timescale 1ns/1ps
module scad_cond_eval (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  logic n, z, c, v;
  always_comb begin
    {n, z, c, v} = flags;
    case (cond[3:1])
      3'h0: pass = z;
      3'h1: pass = c;
      3'h2: pass = n;
      3'h3: pass = v;
      3'h4: pass = c & ~z;
      3'h5: pass = (n == v);
      3'h6: pass = ~z & (n == v);
      default: pass = 1'b1;
    endcase
    if (cond[0] && cond[3:1] != 3'h7) begin
      pass = ~pass;
    end
  end
endmodule : scad_cond_eval

//--- tb/scad_core_model.sv
`timescale 1ns/1ps
module scad_core_model (
  input wire logic rawSel,
  input wire logic [31:0] rawWord,
  input wire logic [3:0] cond,
  input wire logic dir,
  input wire logic [3:0] primary_reg_select,
  input wire logic [3:0] rd,
  input wire logic [2:0] o2,
  input wire logic [3:0] secondary_reg_select,
  output logic [31:0] instr
);
  import scad_pkg::*;
  // ==========================================
  // Instruction composer
  // Raw path exists only for deliberately foreign or undefined words
  assign instr = rawSel ? rawWord :
    {cond, XferClass, 3'h0, dir, primary_reg_select, rd, SysCpNum, o2, 1'b1, secondary_reg_select};
endmodule : scad_core_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import scad_pkg::*;
  logic clk, rst_b, instrValid, rawSel, dir, undefTrap, done, readValid, writeStrobe;
  logic [31:0] rawWord, instr, coreWriteData, cacheIdInfo, readData, writeData;
  logic [4:0] coreMode;
  logic [3:0] coreFlags, cond, primary_reg_select, rd, secondary_reg_select, readDest, primaryRegSelect, secondaryRegSelect;
  logic [2:0] o2, subOp1, subOp2;
  int n_fail, checks_done;
  logic [31:0] raws [4] = '{32'hee000f00, 32'hed900f00, 32'hec800f00, 32'hee100e10};
  logic [3:0] rexp [4] = '{4'hc, 4'hc, 4'hc, 4'h8};
  scad_core_model core (.rawSel(rawSel), .rawWord(rawWord), .cond(cond), .dir(dir),
    .primary_reg_select(primary_reg_select), .rd(rd), .o2(o2), .secondary_reg_select(secondary_reg_select), .instr(instr));
  scad_decode uut (.clk(clk), .rst_b(rst_b), .instrValid(instrValid), .instr(instr),
    .coreMode(coreMode), .coreFlags(coreFlags), .coreWriteData(coreWriteData),
    .cacheIdInfo(cacheIdInfo), .undefTrap(undefTrap), .done(done), .readValid(readValid),
    .readDest(readDest), .readData(readData), .writeStrobe(writeStrobe),
    .primaryRegSelect(primaryRegSelect), .secondaryRegSelect(secondaryRegSelect),
    .subOp1(subOp1), .subOp2(subOp2), .writeData(writeData));
  // ==========================================
  // Clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Pulses sampled mid-cycle; they stay high across back-to-back issues while instrValid is held
  task automatic issue(input logic [4:0] m, input logic [31:0] wd, input logic [3:0] e);
    coreMode = m;
    coreWriteData = wd;
    if (!instrValid) begin
      instrValid = 1'b1;
    end
    @(negedge clk);
    chk("pulses", {28'h0, e}, {28'h0, done, undefTrap, readValid, writeStrobe});
  endtask : issue
  // Valid held low one cycle: pulses fall, read outputs clear
  task automatic idle();
    instrValid = 1'b0;
    @(negedge clk);
    chk("idle", 32'h0, {28'h0, done, undefTrap, readValid, writeStrobe});
    chk("idleData", 32'h0, readData);
    chk("idleDest", 32'h0, {28'h0, readDest});
  endtask : idle
  // ==========================================
  // Scenarios
  task automatic t_regs();
    o2 = 3'h5;
    secondary_reg_select = 4'ha;
    for (int i = 1; i < 16; i++) begin
      primary_reg_select = i[3:0];
      dir = 1'b0;
      issue(5'h13, 32'h11111111 * i, 4'h9);
      chk("writeData", 32'h11111111 * i, writeData);
    end
    chk("secondary", 32'ha, {28'h0, secondaryRegSelect});
    chk("subOp2", 32'h5, {29'h0, subOp2});
    chk("subOp1", 32'h0, {29'h0, subOp1});
    for (int i = 1; i < 16; i++) begin
      primary_reg_select = i[3:0];
      rd = 4'(15 - i);
      dir = 1'b1;
      issue(5'h1f, 32'h0, 4'ha);
      chk("primary", 32'(i), {28'h0, primaryRegSelect});
      chk("readDest", 32'(15 - i), {28'h0, readDest});
      chk("readData", 32'h11111111 * i, readData);
    end
    idle();
  endtask : t_regs
  task automatic t_reg0();
    primary_reg_select = 4'h0;
    dir = 1'b0;
    issue(5'h13, 32'hffffffff, 4'h9);
    dir = 1'b1;
    issue(5'h13, 32'h0, 4'ha);
    chk("reg0", 32'hc0ffee01, readData);
    primary_reg_select = 4'h7;
    dir = 1'b0;
    issue(5'h13, 32'h600dcafe, 4'h9);
    dir = 1'b1;
    issue(5'h13, 32'h0, 4'ha);
    chk("readback", 32'h600dcafe, readData);
    idle();
  endtask : t_reg0
  task automatic t_user();
    primary_reg_select = 4'h3;
    issue(UserMode, 32'h0, 4'hc);
    dir = 1'b0;
    issue(UserMode, 32'h5a5a5a5a, 4'hc);
    coreFlags = 4'h0;
    cond = 4'h0;
    issue(5'h13, 32'hdeadbeef, 4'h8);
    coreFlags = 4'h4;
    dir = 1'b1;
    issue(5'h13, 32'h0, 4'ha);
    chk("unchanged", 32'h33333333, readData);
    idle();
  endtask : t_user
  task automatic t_undef();
    rawSel = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rawWord = raws[i];
      issue(5'h13, 32'h0, rexp[i]);
    end
    rawSel = 1'b0;
    idle();
  endtask : t_undef
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {rst_b, instrValid, rawSel, dir, rawWord, coreWriteData} = '0;
    {coreMode, coreFlags, primary_reg_select, rd, o2, secondary_reg_select} = '0;
    cond = 4'he;
    cacheIdInfo = 32'hc0ffee01;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_reg0();
    t_user();
    t_undef();
    give_verdict();
  end
endmodule : testbench
